// ### common/stats_led_pkg.sv
// Constants for the LED stretch control and retrain statistics block
package stats_led_pkg;

  // Management register addresses
  localparam logic [15:0] ADDR_TONE_FREQ   = 16'hA89E;
  localparam logic [15:0] ADDR_RETRAIN_CNT = 16'hA89F;
  localparam logic [15:0] ADDR_LINK_LOSS   = 16'hA8A0;
  localparam logic [15:0] ADDR_GOOD_FR     = 16'hA8A9;
  localparam logic [15:0] ADDR_PAIR_A      = 16'hA8AA;
  localparam logic [15:0] ADDR_PAIR_B      = 16'hA8AB;
  localparam logic [15:0] ADDR_PAIR_C      = 16'hA8AC;
  localparam logic [15:0] ADDR_PAIR_D      = 16'hA8AD;
  localparam logic [15:0] ADDR_LED_CTL     = 16'hA8EC;

  // Control register layout
  localparam int          CTL_PASS_BIT    = 15;
  localparam int          CTL_STRETCH_LSB = 5;
  localparam logic [15:0] CTL_RESET       = 16'h0000;

  // Statistics reset value and saturation ceiling
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;

  // Counter slots
  localparam int CNT_RETRAIN = 0;
  localparam int CNT_LINK    = 1;
  localparam int CNT_GOOD_FR = 2;
  localparam int NUM_CNT     = 3;

  localparam int NUM_LEDS  = 5;
  localparam int NUM_PAIRS = 4;

  // Blink timing: one blink cycle is two half periods
  localparam int CLK_PERIOD_NS     = 4;
  localparam int BLINK_HALF_US     = 40;
  localparam int BLINK_HALF_CYCLES =
    (BLINK_HALF_US * 1000) / CLK_PERIOD_NS;
  localparam logic [1:0] STRETCH_TICKS = 2'h2;

  typedef enum logic [1:0] {
    FUNC_OFF   = 2'h0,
    FUNC_BLINK = 2'h1,
    FUNC_ON    = 2'h2,
    FUNC_DRAIN = 2'h3
  } led_func_t;

endpackage

// ### hdl/led_lane.sv
// One LED lane: source stretching, blink and function select
`timescale 1ns/100ps
module led_lane (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // Timing and control
  input  wire logic       blink_tick,
  input  wire logic       stretch_en,
  input  wire logic [1:0] func,
  // Source and drive
  input  wire logic       src,
  output logic            led_out
);

  logic [1:0] hold_reg;
  logic       phase_reg;
  logic       stretched;
  logic       led_next;
  stats_led_pkg::led_func_t func_sel;

  assign func_sel = stats_led_pkg::led_func_t'(func);

  // Source held for a full blink cycle after it drops
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_reg <= 2'h0;
    end else if (src && stretch_en) begin
      hold_reg <= stats_led_pkg::STRETCH_TICKS; // see (RQ3)
    end else if (blink_tick && hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end

  // Disabling stretch mid-hold drops the tail at once
  assign stretched = src || (stretch_en && hold_reg != 2'h0); // see (RQ3)

  // Phase restarts lit so a short burst is always seen
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 1'b0;
    end else if (!stretched) begin
      phase_reg <= 1'b0;
    end else if (blink_tick) begin
      phase_reg <= ~phase_reg;
    end
  end

  // Drain mode drives the level only; pin drive type lives outside
  always_comb begin
    case (func_sel)
      stats_led_pkg::FUNC_OFF:   led_next = 1'b0;
      stats_led_pkg::FUNC_BLINK: led_next = stretched && !phase_reg; // see (RQ13)
      stats_led_pkg::FUNC_ON:    led_next = stretched;
      stats_led_pkg::FUNC_DRAIN: led_next = stretched;
      default:                   led_next = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      led_out <= 1'b0;
    end else begin
      led_out <= led_next;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_src_drop;
    src && stretch_en ##1 !src && stretch_en;
  endsequence

  a_stretch_hold: assert property ( // see (RQ3)
    s_src_drop |-> stretched)
    else $error("stretched source dropped with its source");

  a_stretch_off: assert property ( // see (RQ3)
    !stretch_en |-> stretched == src)
    else $error("source altered while stretch disabled");

  a_blink_dark: assert property ( // see (RQ13)
    func == 2'h1 && !stretched |=> !led_out)
    else $error("blink lamp lit with idle source");

  a_blink_start: assert property ( // see (RQ13)
    func == 2'h1 && $rose(stretched) |=> led_out)
    else $error("blink lamp not lit on new activity");

endmodule

// ### hdl/led_stats_regs.sv
// LED stretch control register and retrain statistics registers
//
// Functional notes
// (RQ1) Pass-through bit 0 blocks core activity from LEDs; 1 lets it in.
// (RQ2) Pass-through bit gates the activity bits of the source status.
// (RQ3) Bits 9..5 stretch LEDs five..one by one blink cycle.
// (RQ4) Software changes stretch bits only by read-modify-write.
// (RQ5) Software writes back reserved control bits and ignores their reads.
// (RQ6) Software sets stretch bits 5..9 to make activity visible.
// (RQ7) Tone register holds interference frequency of last retrain.
// (RQ8) Retrain counter counts retrains since reset, from zero.
// (RQ9) Link loss counter counts link-down episodes since reset.
// (RQ10) Retrain and link loss counters cleared only by reset.
// (RQ11) Good fast-retrain counter counts successful fast retrains.
// (RQ12) Four pair registers hold interference level of last retrain.
// (RQ13) Function 01 blinks the lamp from its stretched source.
// (RQ14) Event counters saturate at all ones.
`timescale 1ns/100ps
module led_stats_regs #(
  parameter int BLINK_CYCLES = stats_led_pkg::BLINK_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Management register port
  input  wire logic [15:0] mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic        mgmt_rd,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  // Gigabit copper core activity
  input  wire logic        gigabit_copper_core_rx_act,
  input  wire logic        gigabit_copper_core_tx_act,
  output logic             src_rx_activity,
  output logic             src_tx_activity,
  // LED lanes
  input  wire logic [9:0]  led_func,
  input  wire logic [4:0]  led_act_sel,
  input  wire logic [4:0]  led_source,
  output logic      [4:0]  led_out,
  // Retrain events and measurements
  input  wire logic        retrain_evt,
  input  wire logic        link_down_evt,
  input  wire logic        fast_retrain_ok_evt,
  input  wire logic [15:0] tone_freq_in,
  input  wire logic [15:0] pair_a_level_in,
  input  wire logic [15:0] pair_b_level_in,
  input  wire logic [15:0] pair_c_level_in,
  input  wire logic [15:0] pair_d_level_in
);

  localparam int BW = $clog2(BLINK_CYCLES);
  localparam int NL = stats_led_pkg::NUM_LEDS;
  localparam int NP = stats_led_pkg::NUM_PAIRS;
  localparam int NC = stats_led_pkg::NUM_CNT;

  generate
    if (BLINK_CYCLES < 2) begin : g_bad_blink
      $error("BLINK_CYCLES must be at least 2");
    end
  endgenerate

  logic [15:0]   ctl_reg;
  logic [15:0]   tone_reg;
  logic [15:0]   pair_reg [NP];
  logic [15:0]   pair_in  [NP];
  logic [15:0]   cnt_reg  [NC];
  logic [NC-1:0] evt;
  logic [BW-1:0] blink_cnt_reg;
  logic          blink_tick;
  logic          pass_en;
  logic          rx_gated;
  logic          tx_gated;
  logic [4:0]    stretch_on;
  logic [4:0]    lane_src;
  logic [15:0]   rdata_next;

  assign pass_en    = ctl_reg[stats_led_pkg::CTL_PASS_BIT];
  assign stretch_on = ctl_reg[stats_led_pkg::CTL_STRETCH_LSB +: NL];

  // Whole word is stored, reserved fields included, so that software
  // read-modify-write returns what it wrote
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl_reg <= stats_led_pkg::CTL_RESET;
    end else if (mgmt_wr && mgmt_addr == stats_led_pkg::ADDR_LED_CTL) begin
      ctl_reg <= mgmt_wdata;
    end
  end

  // Core activity reaches the lamps only through the pass-through bit
  assign rx_gated = gigabit_copper_core_rx_act && pass_en; // see (RQ1)
  assign tx_gated = gigabit_copper_core_tx_act && pass_en; // see (RQ1)

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_rx_activity <= 1'b0;
      src_tx_activity <= 1'b0;
    end else begin
      src_rx_activity <= rx_gated; // see (RQ2)
      src_tx_activity <= tx_gated; // see (RQ2)
    end
  end

  // Half-period blink tick shared by all lanes keeps lamps in step
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_reg <= '0;
    end else if (blink_tick) begin
      blink_cnt_reg <= '0;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + BW'(1);
    end
  end

  assign blink_tick = (blink_cnt_reg == BW'(BLINK_CYCLES - 1));

  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_lane
      assign lane_src[gi] = led_source[gi] ||
        (led_act_sel[gi] && (rx_gated || tx_gated)); // see (RQ1)
      led_lane u_lane (
        .mclk       (mclk),
        .rstn       (rstn),
        .blink_tick (blink_tick),
        .stretch_en (stretch_on[gi]),
        .func       (led_func[2*gi +: 2]),
        .src        (lane_src[gi]),
        .led_out    (led_out[gi])
      );
    end
  endgenerate

  // Tone and pair levels are snapshots of the most recent retrain
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tone_reg <= stats_led_pkg::STAT_RESET;
    end else if (retrain_evt) begin
      tone_reg <= tone_freq_in; // see (RQ7)
    end
  end

  assign pair_in[0] = pair_a_level_in;
  assign pair_in[1] = pair_b_level_in;
  assign pair_in[2] = pair_c_level_in;
  assign pair_in[3] = pair_d_level_in;

  generate
    for (gi = 0; gi < NP; gi++) begin : g_pair
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          pair_reg[gi] <= stats_led_pkg::STAT_RESET;
        end else if (retrain_evt) begin
          pair_reg[gi] <= pair_in[gi]; // see (RQ12)
        end
      end
    end
  endgenerate

  assign evt[stats_led_pkg::CNT_RETRAIN] = retrain_evt;
  assign evt[stats_led_pkg::CNT_LINK]    = link_down_evt;
  assign evt[stats_led_pkg::CNT_GOOD_FR] = fast_retrain_ok_evt;

  // No clear path: negotiation activity never touches these counts.
  // Saturation keeps a stuck count readable as "many" instead of zero.
  generate
    for (gi = 0; gi < NC; gi++) begin : g_cnt
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          cnt_reg[gi] <= stats_led_pkg::STAT_RESET; // see (RQ10)
        end else if (evt[gi] && cnt_reg[gi] != stats_led_pkg::CNT_MAX) begin
          cnt_reg[gi] <= cnt_reg[gi] + 16'h0001; // see (RQ8) (RQ9) (RQ11) (RQ14)
        end
      end
    end
  endgenerate

  // Unmapped addresses read as zero
  always_comb begin
    case (mgmt_addr)
      stats_led_pkg::ADDR_TONE_FREQ:
        rdata_next = tone_reg;
      stats_led_pkg::ADDR_RETRAIN_CNT:
        rdata_next = cnt_reg[stats_led_pkg::CNT_RETRAIN];
      stats_led_pkg::ADDR_LINK_LOSS:
        rdata_next = cnt_reg[stats_led_pkg::CNT_LINK];
      stats_led_pkg::ADDR_GOOD_FR:
        rdata_next = cnt_reg[stats_led_pkg::CNT_GOOD_FR];
      stats_led_pkg::ADDR_PAIR_A: rdata_next = pair_reg[0];
      stats_led_pkg::ADDR_PAIR_B: rdata_next = pair_reg[1];
      stats_led_pkg::ADDR_PAIR_C: rdata_next = pair_reg[2];
      stats_led_pkg::ADDR_PAIR_D: rdata_next = pair_reg[3];
      stats_led_pkg::ADDR_LED_CTL: rdata_next = ctl_reg;
      default:                    rdata_next = 16'h0000;
    endcase
  end

  // Read data is held until the next read
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= rdata_next;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_act_blocked: assert property ( // see (RQ1)
    !ctl_reg[15] && !$past(ctl_reg[15]) |->
      !src_rx_activity && !src_tx_activity)
    else $error("core activity leaked while pass-through off");

  a_act_passed: assert property ( // see (RQ2)
    ctl_reg[15] && gigabit_copper_core_tx_act |=> src_tx_activity)
    else $error("tx activity not passed to source status");

  a_tone_capture: assert property ( // see (RQ7)
    retrain_evt ##1 !retrain_evt [*2] |->
      tone_reg == $past(tone_freq_in, 2))
    else $error("tone frequency not held from last retrain");

  a_retrain_count: assert property ( // see (RQ8)
    retrain_evt && cnt_reg[0] != 16'hFFFF |=>
      cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
    else $error("retrain counter missed an event");

  a_link_count: assert property ( // see (RQ9)
    link_down_evt && cnt_reg[1] != 16'hFFFF |=>
      cnt_reg[1] == $past(cnt_reg[1]) + 16'h0001)
    else $error("link loss counter missed an event");

  a_count_hold: assert property ( // see (RQ10)
    !retrain_evt && !link_down_evt |=>
      $stable(cnt_reg[0]) && $stable(cnt_reg[1]))
    else $error("counter changed without its event");

  a_fr_count: assert property ( // see (RQ11)
    fast_retrain_ok_evt && cnt_reg[2] != 16'hFFFF |=>
      cnt_reg[2] == $past(cnt_reg[2]) + 16'h0001)
    else $error("fast retrain counter missed an event");

  a_pair_capture: assert property ( // see (RQ12)
    retrain_evt |=> pair_reg[3] == $past(pair_d_level_in) &&
      pair_reg[0] == $past(pair_a_level_in))
    else $error("pair level not captured on retrain");

  a_count_sat: assert property ( // see (RQ14)
    cnt_reg[0] == 16'hFFFF |=> cnt_reg[0] == 16'hFFFF)
    else $error("retrain counter wrapped past all ones");

endmodule

// ### test/tb_led_stats_regs.sv
// Self-checking bench for the LED stretch and retrain statistics block
`timescale 1ns/100ps
module tb_led_stats_regs;
  // Short blink tick keeps the stretch checks quick
  localparam int BLINK = 4;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] mgmt_addr = 16'h0000;
  logic        mgmt_wr = 1'b0;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic        mgmt_rd = 1'b0;
  logic [15:0] mgmt_rdata;
  logic        mgmt_rvalid;
  logic        rx_act = 1'b0;
  logic        tx_act = 1'b0;
  logic        src_rx_activity;
  logic        src_tx_activity;
  logic [9:0]  led_func = 10'h000;
  logic [4:0]  led_act_sel = 5'h00;
  logic [4:0]  led_source = 5'h00;
  logic [4:0]  led_out;
  logic        retrain_evt = 1'b0;
  logic        link_down_evt = 1'b0;
  logic        fast_retrain_ok_evt = 1'b0;
  logic [15:0] tone = 16'h0000;
  logic [15:0] pv [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [31:0] seed = 32'h0000002F;
  int          error_cnt = 0;
  int          checked = 0;
  int          cycles = 0;
  int          n [3];
  logic [15:0] d;
  logic [15:0] ctl_sh;
  logic        dark;
  logic [15:0] addrs [10] = '{stats_led_pkg::ADDR_TONE_FREQ,
    stats_led_pkg::ADDR_RETRAIN_CNT, stats_led_pkg::ADDR_LINK_LOSS,
    stats_led_pkg::ADDR_GOOD_FR, stats_led_pkg::ADDR_PAIR_A,
    stats_led_pkg::ADDR_PAIR_B, stats_led_pkg::ADDR_PAIR_C,
    stats_led_pkg::ADDR_PAIR_D, stats_led_pkg::ADDR_LED_CTL, 16'hA8A1};

  always #2 mclk = ~mclk;

  led_stats_regs #(.BLINK_CYCLES(BLINK)) led_stats_regs_i (
    .mclk                       (mclk),
    .rstn                       (rstn),
    .mgmt_addr                  (mgmt_addr),
    .mgmt_wr                    (mgmt_wr),
    .mgmt_wdata                 (mgmt_wdata),
    .mgmt_rd                    (mgmt_rd),
    .mgmt_rdata                 (mgmt_rdata),
    .mgmt_rvalid                (mgmt_rvalid),
    .gigabit_copper_core_rx_act (rx_act),
    .gigabit_copper_core_tx_act (tx_act),
    .src_rx_activity            (src_rx_activity),
    .src_tx_activity            (src_tx_activity),
    .led_func                   (led_func),
    .led_act_sel                (led_act_sel),
    .led_source                 (led_source),
    .led_out                    (led_out),
    .retrain_evt                (retrain_evt),
    .link_down_evt              (link_down_evt),
    .fast_retrain_ok_evt        (fast_retrain_ok_evt),
    .tone_freq_in               (tone),
    .pair_a_level_in            (pv[0]),
    .pair_b_level_in            (pv[1]),
    .pair_c_level_in            (pv[2]),
    .pair_d_level_in            (pv[3])
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Gated activity as the source status should show it
  function automatic logic gated(input logic act, input logic [15:0] ctl);
    return act & ctl[stats_led_pkg::CTL_PASS_BIT];
  endfunction

  task automatic results();
    $display("checked %0d, error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] v);
    @(negedge mclk);
    mgmt_addr = a;
    mgmt_wdata = v;
    mgmt_wr = 1'b1;
    @(negedge mclk);
    mgmt_wr = 1'b0;
  endtask

  // Answer is registered on the read edge and checked half a cycle after it
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge mclk);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge mclk);
    mgmt_rd = 1'b0;
    chk(mgmt_rvalid, 1'b1, "rvalid");
    chk(mgmt_rdata, exp, "rdata");
  endtask

  // Stretch bits change only by read-modify-write, reserved bits kept
  task automatic ctl_rmw(input logic [4:0] lamps);
    reg_rd(stats_led_pkg::ADDR_LED_CTL, ctl_sh);
    ctl_sh = (mgmt_rdata & 16'hFC1F) | {6'h00, lamps, 5'h00};
    reg_wr(stats_led_pkg::ADDR_LED_CTL, ctl_sh);
  endtask

  // Holds one event line high for len cycles; each cycle counts once
  task automatic pulse(input int which, input int len);
    @(negedge mclk);
    retrain_evt = (which == 0);
    link_down_evt = (which == 1);
    fast_retrain_ok_evt = (which == 2);
    repeat (len) @(negedge mclk);
    retrain_evt = 1'b0;
    link_down_evt = 1'b0;
    fast_retrain_ok_evt = 1'b0;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      $display("mismatch at %0t: run too long", $time);
      results();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    foreach (addrs[i]) begin
      reg_rd(addrs[i], 16'h0000);
    end
    $display("test reset values done");

    d = 16'(rnd());
    reg_wr(stats_led_pkg::ADDR_LED_CTL, d);
    reg_rd(stats_led_pkg::ADDR_LED_CTL, d);
    reg_wr(stats_led_pkg::ADDR_RETRAIN_CNT, 16'h1234);
    reg_rd(stats_led_pkg::ADDR_RETRAIN_CNT, 16'h0000);
    $display("test control access done");

    led_act_sel = 5'h1F;
    led_func = 10'h2AA;
    for (int k = 0; k < 12; k++) begin
      d = (k < 6) ? 16'h0000 : 16'h8000;
      if (k == 0 || k == 6) reg_wr(stats_led_pkg::ADDR_LED_CTL, d);
      @(negedge mclk);
      {rx_act, tx_act} = (k % 6 == 0) ? 2'h3 : 2'(rnd());
      @(negedge mclk);
      chk(src_rx_activity, gated(rx_act, d), "rx gate");
      chk(src_tx_activity, gated(tx_act, d), "tx gate");
      @(negedge mclk);
      chk(led_out, {5{gated(rx_act | tx_act, d)}}, "act led");
    end
    rx_act = 1'b0;
    tx_act = 1'b0;
    led_act_sel = 5'h00;
    $display("test pass-through done");

    // Only the retrain pulse captures, so the levels are set once
    tone = 16'(rnd());
    foreach (pv[p]) pv[p] = 16'(rnd());
    for (int w = 0; w < 3; w++) begin
      n[w] = rnd() % 5 + 1;
      pulse(w, n[w]);
      reg_wr(stats_led_pkg::ADDR_LED_CTL, 16'h8000);
    end
    reg_rd(stats_led_pkg::ADDR_RETRAIN_CNT, 16'(n[0]));
    reg_rd(stats_led_pkg::ADDR_LINK_LOSS, 16'(n[1]));
    reg_rd(stats_led_pkg::ADDR_GOOD_FR, 16'(n[2]));
    reg_rd(stats_led_pkg::ADDR_TONE_FREQ, tone);
    for (int p = 0; p < 4; p++) reg_rd(addrs[4 + p], pv[p]);
    $display("test events done");

    // Random reserved bits must survive every stretch update
    ctl_sh = (16'(rnd()) & 16'h7C1F) | 16'h8000;
    reg_wr(stats_led_pkg::ADDR_LED_CTL, ctl_sh);
    for (int i = 0; i < 5; i++) begin
      ctl_rmw(5'h01 << i);
      @(negedge mclk);
      led_source = 5'h1F;
      @(negedge mclk);
      led_source = 5'h00;
      repeat (3) @(negedge mclk);
      chk(led_out, 5'h01 << i, "stretch lane");
      repeat (12) @(negedge mclk);
      chk(led_out, 5'h00, "stretch end");
    end
    led_func = 10'h000;
    led_source = 5'h1F;
    repeat (2) @(negedge mclk);
    chk(led_out, 5'h00, "func off");
    led_source = 5'h00;
    led_func = 10'h155;
    // Let the stretched lane run dry so every phase restarts lit
    repeat (3 * BLINK) @(negedge mclk);
    led_source = 5'h1F;
    @(negedge mclk);
    chk(led_out, 5'h1F, "blink lit");
    dark = 1'b0;
    repeat (2 * BLINK + 2) begin
      @(negedge mclk);
      if (led_out === 5'h00) dark = 1'b1;
    end
    chk(dark, 1'b1, "blink dark");
    led_source = 5'h00;
    $display("test lamps done");

    pulse(0, 65540);
    reg_rd(stats_led_pkg::ADDR_RETRAIN_CNT, 16'hFFFF);
    @(negedge mclk);
    rstn = 1'b0;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    reg_rd(stats_led_pkg::ADDR_RETRAIN_CNT, 16'h0000);
    reg_rd(stats_led_pkg::ADDR_LINK_LOSS, 16'h0000);
    $display("test saturation done");
    results();
  end
endmodule
